// ===== shared/pmrs_pkg.sv
// Constants and types shared by the power monitor result scaling block.
// Assumes one 250 MHz reference clock and an Avalon-MM register port.
//
// How it works
// - The range bit picks a 163.84 mV (5 uV steps) or 40.96 mV (1.25 uV steps) shunt span.
// - Bus voltage spans 0 to 85 V, each result step worth 3.125 mV.
// - Shunt and bus results are presented as 16-bit words.
// - The shunt result is a signed code so both current directions show.
// - The bus result is reported only as a non-negative unsigned code.
// - Die temperature is a signed 12-bit code of 125 milli-degree steps.
// - The temperature code spans -256 to +255.875 degrees even if the package limits use.
// - Current is recomputed after every new shunt result with the held calibration.
// - A zero calibration constant yields a zero current result.
// - Power is a 24-bit unsigned word, each code worth 0.2 current steps in watts.
// - Eight conversion times are offered: 50, 84, 150, 280, 540, 1052, 2074, 4120 us.
// - One output sample per averaging window; period is conversion time times count.

package pmrs_pkg;

  localparam int unsigned CLK_MHZ = 250;

  // Conversion times in microseconds and their length in reference cycles
  localparam int unsigned CONV_US [8] = '{50, 84, 150, 280, 540, 1052, 2074,
                                          4120};
  localparam int unsigned CONV_CYC [8] = '{
    CONV_US[0] * CLK_MHZ, CONV_US[1] * CLK_MHZ, CONV_US[2] * CLK_MHZ,
    CONV_US[3] * CLK_MHZ, CONV_US[4] * CLK_MHZ, CONV_US[5] * CLK_MHZ,
    CONV_US[6] * CLK_MHZ, CONV_US[7] * CLK_MHZ};
  localparam int CNT_W = 21;

  // Averaging counts 1,4,16,64,128,256,512,1024 as right shifts
  localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7,
                                           4'h8, 4'h9, 4'ha};
  localparam int AVG_W = 10;
  localparam int ACC_W = 27;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_CAL     = 8'h04;
  localparam logic [7:0] OFS_SHUNT   = 8'h08;
  localparam logic [7:0] OFS_BUS     = 8'h0c;
  localparam logic [7:0] OFS_TEMP    = 8'h10;
  localparam logic [7:0] OFS_CURRENT = 8'h14;
  localparam logic [7:0] OFS_POWER   = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;

  // Configuration fields
  localparam int CFG_RANGE_POS = 0;
  localparam int CFG_CT_POS    = 1;
  localparam int CFG_AVG_POS   = 4;
  localparam int CFG_W         = 7;
  localparam logic [CFG_W-1:0] CONFIG_RST = 7'h0a;
  localparam logic [15:0]      CAL_RST    = 16'h0000;

  // Status fields
  localparam int STS_READY_POS = 0;
  localparam int STS_BUSY_POS  = 1;

  // Current = shunt * 4096 / cal, power = |current| * bus / 64
  localparam int CUR_SHIFT = 12;
  localparam int DIV_W     = 17 + CUR_SHIFT;
  localparam int PWR_SHIFT = 6;
  localparam logic [15:0] CUR_POS_MAX = 16'h7fff;
  localparam logic [15:0] CUR_NEG_MIN = 16'h8000;
  localparam logic [23:0] PWR_MAX     = 24'hffffff;

  // Channel order in the result set
  localparam int CH_SHUNT = 0;
  localparam int CH_BUS   = 1;
  localparam int CH_TEMP  = 2;
  localparam int N_CH     = 3;

  typedef enum logic [1:0] {
    PMRS_IDLE = 2'b00,
    PMRS_DIV  = 2'b01,
    PMRS_PWR  = 2'b11
  } pmrs_calc_t;

  typedef struct packed {
    logic signed [15:0] shunt;
    logic [15:0]        bus;
    logic signed [11:0] temp;
  } pmrs_sample_t;

endpackage : pmrs_pkg

// ===== core/pmrs_avg.sv
// Window averager for one measurement channel.
// Assumes the caller pulses sample_en once per conversion and last on the
// final conversion of a window.
`timescale 1ns/100ps
`default_nettype none

module pmrs_avg
  import pmrs_pkg::*;
#(
  parameter bit IS_SIGNED = 1'b1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control
  input  wire logic        clear,
  input  wire logic        sample_en,
  input  wire logic        last,
  input  wire logic [3:0]  shift,
  // Data
  input  wire logic [15:0] din,
  output logic [15:0]      dout
);

  typedef struct packed {
    logic signed [ACC_W-1:0] acc;
    logic [15:0]             result;
  } pmrs_avg_state_t;

  pmrs_avg_state_t st;
  pmrs_avg_state_t next_st;

  always_comb begin
    logic signed [ACC_W-1:0] ext;
    logic signed [ACC_W-1:0] sum;
    ext = IS_SIGNED ? ACC_W'($signed(din)) : ACC_W'(din);
    sum = st.acc + ext;
    next_st = st;
    if (clear) begin
      next_st.acc = '0;
    end else if (sample_en) begin
      if (last) begin
        next_st.acc    = '0;
        next_st.result = 16'(sum >>> shift);
      end else begin
        next_st.acc = sum;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.result;

endmodule : pmrs_avg

`default_nettype wire

// ===== core/pmrs_top.sv
// Result scaling core: conversion pacing, averaging, current and power.
// Assumes the analog front end holds settled codes at each conversion end
// and that software reaches the registers over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module pmrs_top
  import pmrs_pkg::*;
#(
  parameter int unsigned CONV_CYCLES [8] = CONV_CYC
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Analog front end
  input  wire logic [15:0] ADC_SHUNT_CODE,
  input  wire logic [15:0] ADC_BUS_CODE,
  input  wire logic [11:0] ADC_TEMP_CODE,
  output logic             SHUNT_RANGE_SELECT,
  output logic             CONV_DONE
);

  typedef struct packed {
    logic [CFG_W-1:0]  config_r;
    logic [15:0]       cal;
    logic [CNT_W-1:0]  conv_cnt;
    logic [AVG_W-1:0]  avg_cnt;
    logic              tick;
    logic              win_end;
    logic              res_new;
    pmrs_calc_t        calc;
    logic [4:0]        step;
    logic [DIV_W-1:0]  dvd;
    logic [16:0]       rem;
    logic              neg;
    logic [15:0]       current;
    logic [23:0]       power;
    logic              ready;
    logic              ack;
    logic [31:0]       rdata;
  } pmrs_top_state_t;

  pmrs_top_state_t st;
  pmrs_top_state_t next_st;

  // Merge a write into a narrow register under byte enables
  function automatic logic [15:0] be_merge(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : be_merge

  logic [2:0]       ct_sel;
  logic [2:0]       avg_sel;
  logic [3:0]       avg_shift;
  logic [AVG_W-1:0] avg_last;
  logic [CNT_W-1:0] conv_last;
  logic             bus_req;
  logic             wr_take;
  logic             rd_take;
  logic             cfg_wr;
  logic [15:0]      ch_in  [N_CH];
  logic [15:0]      ch_out [N_CH];
  pmrs_sample_t     res;

  assign ct_sel    = st.config_r[CFG_CT_POS +: 3];
  assign avg_sel   = st.config_r[CFG_AVG_POS +: 3];
  assign avg_shift = AVG_SHIFT[avg_sel];
  assign avg_last  = AVG_W'((11'h001 << avg_shift) - 11'h001);
  assign conv_last = CNT_W'(CONV_CYCLES[ct_sel] - 1);

  // Avalon request is answered one cycle after it is presented
  assign bus_req = AVS_READ | AVS_WRITE;
  assign wr_take = AVS_WRITE & st.ack;
  assign rd_take = AVS_READ & st.ack;
  assign cfg_wr  = wr_take && (AVS_ADDRESS[7:2] == OFS_CONFIG[7:2]);

  assign ch_in[CH_SHUNT] = ADC_SHUNT_CODE;
  // bus code kept at 3.125 mV steps
  assign ch_in[CH_BUS]   = ADC_BUS_CODE;
  assign ch_in[CH_TEMP]  = 16'($signed(ADC_TEMP_CODE));

  // signed shunt, unsigned bus, signed temp
  generate
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
      pmrs_avg #(
        .IS_SIGNED (c != CH_BUS)
      ) u_avg (
        .clk       (REF_CLK),
        .rst       (RESET),
        .clear     (cfg_wr),
        .sample_en (st.tick),
        .last      (st.win_end),
        .shift     (avg_shift),
        .din       (ch_in[c]),
        .dout      (ch_out[c])
      );
    end
  endgenerate

  assign res.shunt = $signed(ch_out[CH_SHUNT]);
  assign res.bus   = ch_out[CH_BUS];
  // full 12-bit span kept, no clamp to package limits
  assign res.temp  = $signed(ch_out[CH_TEMP][11:0]);

  always_comb begin
    logic [16:0] mag;
    logic [16:0] trial;
    logic [31:0] prod;
    logic [25:0] pwr;
    logic [DIV_W-1:0] q;
    logic [31:0] rd;
    mag   = '0;
    trial = '0;
    prod  = '0;
    pwr   = '0;
    q     = '0;
    rd    = '0;
    next_st         = st;
    next_st.tick    = 1'b0;
    next_st.win_end = 1'b0;
    next_st.res_new = 1'b0;
    next_st.ack     = bus_req & ~st.ack;

    if (cfg_wr || st.conv_cnt >= conv_last) begin
      next_st.conv_cnt = '0;
    end else begin
      next_st.conv_cnt = st.conv_cnt + CNT_W'(1);
    end
    if (!cfg_wr && st.conv_cnt >= conv_last) begin
      next_st.tick    = 1'b1;
      next_st.win_end = (st.avg_cnt >= avg_last);
    end

    if (cfg_wr) begin
      next_st.avg_cnt = '0;
    end else if (st.tick) begin
      if (st.win_end) begin
        next_st.avg_cnt = '0;
      end else begin
        next_st.avg_cnt = st.avg_cnt + AVG_W'(1);
      end
    end
    next_st.res_new = st.tick & st.win_end;

    // Current and power engine
    case (st.calc)
      PMRS_IDLE: begin
        if (st.res_new) begin
          mag = res.shunt[15] ? 17'(-$signed({1'b1, res.shunt}))
                              : {1'b0, res.shunt};
          next_st.neg  = res.shunt[15];
          next_st.dvd  = {mag, CUR_SHIFT'(0)};
          next_st.rem  = '0;
          next_st.step = '0;
          if (st.cal == 16'h0000) begin
            next_st.current = 16'h0000;
            next_st.calc    = PMRS_PWR;
          end else begin
            next_st.calc = PMRS_DIV;
          end
        end
      end
      PMRS_DIV: begin
        // shunt * 4096 / cal, one quotient bit per cycle
        trial = {st.rem[15:0], st.dvd[DIV_W-1]};
        q     = {st.dvd[DIV_W-2:0], 1'b0};
        if (trial >= {1'b0, st.cal}) begin
          next_st.rem = trial - {1'b0, st.cal};
          q[0]        = 1'b1;
        end else begin
          next_st.rem = trial;
        end
        next_st.dvd  = q;
        next_st.step = st.step + 5'h01;
        if (st.step == 5'(DIV_W - 1)) begin
          if (st.neg) begin
            next_st.current = (q > DIV_W'(CUR_NEG_MIN)) ? CUR_NEG_MIN
                              : 16'(-q);
          end else begin
            next_st.current = (q > DIV_W'(CUR_POS_MAX)) ? CUR_POS_MAX
                              : q[15:0];
          end
          next_st.calc = PMRS_PWR;
        end
      end
      PMRS_PWR: begin
        mag  = st.current[15] ? 17'(-$signed({1'b1, st.current}))
                              : {1'b0, st.current};
        prod = 32'(mag[15:0] * res.bus) + (mag[16] ? {res.bus, 16'h0000}
                                                   : 32'h0000_0000);
        pwr  = 26'(prod >> PWR_SHIFT);
        next_st.power = (pwr > 26'(PWR_MAX)) ? PWR_MAX : pwr[23:0];
        next_st.ready = 1'b1;
        next_st.calc  = PMRS_IDLE;
      end
      default: begin
        next_st.calc = PMRS_IDLE;
      end
    endcase

    // Register writes take effect on the edge that sees waitrequest low
    if (wr_take) begin
      case (AVS_ADDRESS[7:2])
        OFS_CONFIG[7:2]: begin
          next_st.config_r = CFG_W'(be_merge(16'(st.config_r),
                                             AVS_WRITEDATA, AVS_BYTEENABLE));
        end
        OFS_CAL[7:2]: begin
          next_st.cal = be_merge(st.cal, AVS_WRITEDATA, AVS_BYTEENABLE);
        end
        default: begin
        end
      endcase
    end

    // Read data is captured as the request is first seen
    case (AVS_ADDRESS[7:2])
      OFS_CONFIG[7:2]:  rd = 32'(st.config_r);
      OFS_CAL[7:2]:     rd = {16'h0000, st.cal};
      OFS_SHUNT[7:2]:   rd = {16'h0000, res.shunt};
      OFS_BUS[7:2]:     rd = {16'h0000, res.bus};
      OFS_TEMP[7:2]:    rd = {20'h00000, res.temp};
      OFS_CURRENT[7:2]: rd = {16'h0000, st.current};
      OFS_POWER[7:2]:   rd = {8'h00, st.power};
      OFS_STATUS[7:2]: begin
        rd[STS_READY_POS] = st.ready;
        rd[STS_BUSY_POS]  = (st.calc != PMRS_IDLE);
      end
      default:          rd = 32'h0000_0000;
    endcase
    if (bus_req && !st.ack) begin
      next_st.rdata = rd;
    end

    // Ready clears on a status read; a new result in that cycle wins
    if (rd_take && AVS_ADDRESS[7:2] == OFS_STATUS[7:2]
        && !(st.calc == PMRS_PWR)) begin
      next_st.ready = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      st          <= '0;
      st.config_r <= CONFIG_RST;
      st.cal      <= CAL_RST;
      st.calc     <= PMRS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign AVS_WAITREQUEST = bus_req & ~st.ack;
  assign AVS_READDATA    = st.rdata;
  assign SHUNT_RANGE_SELECT = st.config_r[CFG_RANGE_POS];
  // Pulse marks the edge at which the codes are taken
  assign CONV_DONE = st.tick;

endmodule : pmrs_top

`default_nettype wire

// ===== test/pmrs_assertions.sv
// Port-level checker for pmrs_top, attached by the bind at the foot.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/100ps
`default_nettype none
module pmrs_assertions
  import pmrs_pkg::*;
#(
  parameter int unsigned CONV_CYCLES [8] = CONV_CYC
) (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RESET,
  // Register bus
  input wire logic [7:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // Front end
  input wire logic        SHUNT_RANGE_SELECT,
  input wire logic        CONV_DONE
);
  logic        req;
  logic        rd_ok;
  logic        cfg_wr;
  logic        seen;
  logic        cfg_seen;
  logic        cnt_ok;
  logic [20:0] cnt;
  logic [5:0]  ix;
  assign req    = AVS_READ || AVS_WRITE;
  assign rd_ok  = AVS_READ && !AVS_WAITREQUEST;
  assign ix     = AVS_ADDRESS[7:2];
  assign cfg_wr = AVS_WRITE && !AVS_WAITREQUEST && ix == 6'h00;
  // A config write restarts the pacer, so that interval is not judged
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cnt      <= 21'h0;
      seen     <= 1'b0;
      cfg_seen <= 1'b0;
    end else if (CONV_DONE) begin
      cnt      <= 21'h1;
      seen     <= 1'b1;
      cfg_seen <= cfg_wr;
    end else begin
      cnt      <= cnt + 21'h1;
      cfg_seen <= cfg_seen || cfg_wr;
    end
  end
  always_comb begin
    cnt_ok = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (32'(cnt) == CONV_CYCLES[k]) begin
        cnt_ok = 1'b1;
      end
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  a_wait_first: assert property (
    req && !$past(req) |-> AVS_WAITREQUEST) else $error("no wait cycle");
  a_wait_one: assert property (
    req && AVS_WAITREQUEST ##1 req |-> !AVS_WAITREQUEST)
    else $error("second wait cycle");
  a_done_pulse: assert property (
    CONV_DONE |=> !CONV_DONE) else $error("done longer than a cycle");
  a_done_spacing: assert property (
    CONV_DONE && seen && !cfg_seen |-> cnt_ok) else $error("bad spacing");
  a_range_follow: assert property (
    cfg_wr && AVS_BYTEENABLE[0] |=>
    SHUNT_RANGE_SELECT == $past(AVS_WRITEDATA[0])) else $error("range");
  a_range_hold: assert property (
    !$stable(SHUNT_RANGE_SELECT) |-> $past(cfg_wr)) else $error("range");
  a_result_width: assert property (
    rd_ok && ix inside {6'h02, 6'h03, 6'h05} |->
    AVS_READDATA[31:16] == 16'h0) else $error("result wider than 16");
  a_power_width: assert property (
    rd_ok && ix == 6'h06 |-> AVS_READDATA[31:24] == 8'h0)
    else $error("power wider than 24");
endmodule : pmrs_assertions
bind pmrs_top pmrs_assertions #(.CONV_CYCLES(CONV_CYCLES)) pmrs_assertions_i (
  .REF_CLK(REF_CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .SHUNT_RANGE_SELECT(SHUNT_RANGE_SELECT),
  .CONV_DONE(CONV_DONE));
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for pmrs_top with shortened conversion times.
// Assumes the checker file binds itself to the design.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pmrs_pkg::*;
  localparam int unsigned CC [8] = '{100, 104, 108, 112, 116, 120, 124, 128};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'hf;
  logic [31:0] rdata;
  logic [31:0] dummy;
  logic        waitreq;
  logic        range_sel;
  logic        done;
  logic [15:0] shunt = 16'h0;
  logic [15:0] bus_voltage_result = 16'h0;
  logic [11:0] temp = 12'h0;
  int          miscompares = 0;
  int          compares = 0;
  int          cyc = 0;
  int          last = 0;
  pmrs_top #(.CONV_CYCLES(CC)) pmrs_top_i (
    .REF_CLK(clk), .RESET(rst), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .ADC_SHUNT_CODE(shunt), .ADC_BUS_CODE(bus_voltage_result), .ADC_TEMP_CODE(temp),
    .SHUNT_RANGE_SELECT(range_sel), .CONV_DONE(done));
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] e, input string what);
    compares++;
    if (got !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, e);
    end
  endtask : chk
  // Request held until the edge that sees waitrequest low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int   n;
    logic ok;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    rd_en <= !wr;
    wr_en <= wr;
    while (!ok && n < 20) begin
      @(posedge clk);
      ok = (waitreq === 1'b0);
      q = rdata;
      n++;
    end
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (!ok) begin
      miscompares++;
      $display("CHECK FAILED at %0t: bus timeout", $time);
      summarize();
    end
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, what);
  endtask : rd
  task wait_done(input bit check, input int unsigned e);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: no conversion", $time);
      summarize();
    end
    @(posedge clk);
    if (check) begin
      chk(cyc - last, e, "conversion spacing");
    end
    last = cyc;
  endtask : wait_done
  function automatic logic [15:0] fc(input longint s, input longint c);
    longint q;
    if (c == 0) begin
      return 16'h0;
    end
    q = (s * 4096) / c;
    q = (q > 32767) ? 32767 : q;
    q = (q < -32768) ? -32768 : q;
    return q[15:0];
  endfunction : fc
  function automatic logic [23:0] fp(input longint c, input longint b);
    longint p;
    p = (((c < 0) ? -c : c) * b) >>> 6;
    return (p > 16777215) ? 24'hffffff : p[23:0];
  endfunction : fp
  // Calibration as software sets it: step is max current over 2^15,
  // so the constant is 25 per amp-milliohm, four times that when narrow
  function automatic logic [15:0] fcal(input int amps, input int mohm,
                                       input bit narrow);
    longint c;
    c = 25 * amps * mohm;
    if (narrow) begin
      c = c * 4;
    end
    return c[15:0];
  endfunction : fcal
  // One setting: range i[0], conversion time i, averaging 1, 4 or 16
  task run(input int i);
    logic [6:0]  cfg;
    logic [15:0] cal;
    logic [15:0] s;
    logic [15:0] b;
    logic [15:0] cur;
    logic [11:0] t;
    longint      ss;
    longint      sb;
    longint      st;
    int          sh;
    bit          first;
    sh = int'(AVG_SHIFT[i % 3]);
    cal = (i < 2) ? 16'(i) : 16'($urandom_range(65535, 2));
    if (i == 2 || i == 5) begin
      cal = fcal(10, 10, i[0]);
    end
    cfg = {3'(i % 3), 3'(i), i[0]};
    first = 1'b1;
    bus(1'b1, OFS_CAL, {16'h0, cal}, dummy);
    bus(1'b1, OFS_CONFIG, {25'h0, cfg}, dummy);
    @(negedge clk);
    chk({31'h0, range_sel}, {31'h0, i[0]}, "range");
    @(posedge clk);
    repeat (2) begin
      ss = 0;
      sb = 0;
      st = 0;
      for (int k = 0; k < (1 << sh); k++) begin
        s = (i == 3) ? 16'h8000 : 16'($urandom);
        b = (i == 3) ? 16'hffff : 16'($urandom);
        t = (i == 3) ? 12'h800 : 12'($urandom);
        shunt <= s;
        bus_voltage_result <= b;
        temp <= t;
        ss += longint'(signed'(s));
        sb += b;
        st += longint'(signed'(t));
        wait_done(!first, CC[i]);
        first = 1'b0;
      end
      repeat (40) @(posedge clk);
      s = 16'(ss >>> sh);
      b = 16'(sb >>> sh);
      t = 12'(st >>> sh);
      cur = fc(longint'(signed'(s)), cal);
      rd(OFS_SHUNT, {16'h0, s}, "shunt");
      rd(OFS_BUS, {16'h0, b}, "bus");
      rd(OFS_TEMP, {20'h0, t}, "temp");
      rd(OFS_CURRENT, {16'h0, cur}, "current");
      rd(OFS_POWER, {8'h0, fp(signed'(cur), b)}, "power");
      rd(OFS_STATUS, 32'h1, "ready");
      rd(OFS_STATUS, 32'h0, "ready cleared");
    end
    $display("setting %0d done", i);
  endtask : run
  initial begin
    void'($urandom(32'h7dfc0d89));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CONFIG, {25'h0, CONFIG_RST}, "config reset");
    rd(OFS_CAL, 32'h0, "cal reset");
    bus(1'b1, OFS_SHUNT, 32'h1234, dummy);
    rd(OFS_SHUNT, 32'h0, "read only");
    rd(8'h40, 32'h0, "unmapped");
    be <= 4'h1;
    bus(1'b1, OFS_CAL, 32'h0000_beef, dummy);
    be <= 4'hf;
    rd(OFS_CAL, 32'h0000_00ef, "byte lane");
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      run(i);
    end
    summarize();
  end
endmodule : testbench
`default_nettype wire
